// ### common/eropt_pkg.sv
// eropt_pkg: constants of the E1 receive output port.
// Assumes a 100 MHz system clock and an APB register bus with 32-bit data.
//
// Overview of operation
// R1: Data-link pins carry serial data and clock only with HDLC off or fractional mode.
// R2: Extracted data link comes from timeslot 16 or any chosen national bits.
// R3: Serial data-link output changes only on the falling edge of its clock.
// R4: Outside logic samples data-link data on the rising edge of its clock.
// R5: With HDLC enabled, the interrupt pin rises on any receiver status change.
// R6: With HDLC enabled, message-end pin rises on last byte read or FIFO overrun.
// R7: Single-rail PCM output carries the stream after elastic store and signaling extractor.
// R8: Elastic store used, not line timed: PCM changes on backplane clock falling edge.
// R9: Store bypassed or line timed: PCM changes on recovered clock falling edge.
// R10: Dual-rail positive output presents positive line pulses in NRZ form.
// R11: Positive-rail output changes only on the recovered clock falling edge.
// R12: Multiplex enable low interleaves all four PCM and signaling streams at 16.384 Mbit/s.
// R13: Multiplex frame pulse is valid at and sampled on the multiplex clock rising edge.
// R14: Multiplexed data changes only on the multiplex clock falling edge.
// R15: Multiplex enable high: each stream on its own pin, multiplexed output unused.
// R16: Signaling output carries extracted bits in positions 5 to 8, channel aligned.
// R17: Negative-rail output presents negative pulses in NRZ, changing on recovered clock fall.
// R18: Multiplexed output emits channels in ascending order, channel 1 first at frame pulse.
`default_nettype none
package eropt_pkg;
    localparam int NCH = 4;
    localparam int AW = 8;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SA = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    // Control field positions, four bits per channel group
    localparam int CTRL_HDLC_EN = 0;
    localparam int CTRL_FRAC_EN = 4;
    localparam int CTRL_BYPASS = 8;
    localparam int CTRL_TS16 = 12;
    localparam int CTRL_LINE_TIMED = 16;
    localparam int CTRL_DUAL = 17;
    localparam int SA_STRIDE = 8;
    localparam int STAT_IRQ = 0;
    localparam int STAT_EOM = 4;
    // Reset values and writable bits
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] SA_RST = 32'h00000000;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [31:0] CTRL_WMASK = 32'h0003FFFF;
    localparam logic [31:0] SA_WMASK = 32'h1F1F1F1F;
    localparam logic [3:0] DLCLK_RST = 4'hF;
    // Frame positions
    localparam logic [4:0] TS_DLINK = 5'h10;
    localparam logic [2:0] SA_FIRST_BIT = 3'h3;
    // Synchroniser vector layout
    localparam int SYNC_W = 8;
    localparam int SY_BP = 4;
    localparam int SY_MCLK = 5;
    localparam int SY_MFP = 6;
    localparam int SY_MUX_ENABLE_N = 7;
endpackage : eropt_pkg
`default_nettype wire

// ### hdl/eropt_sync.sv
// eropt_sync: two-flop synchronisers with edge detection.
// Assumes inputs from pins or foreign clocks, much slower than clk.
`timescale 1ns/1ns
`default_nettype none
module eropt_sync #(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Raw and synchronised signals
    input wire logic [W-1:0] din,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
        logic [W-1:0] prev;
    } eropt_sync_s;
    eropt_sync_s s_q;
    eropt_sync_s s_d;

    always_comb
    begin
        s_d.meta = din;
        s_d.stab = s_q.meta;
        s_d.prev = s_q.stab;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign lvl = s_q.stab;
    assign rise = s_q.stab & ~s_q.prev;
    assign fall = ~s_q.stab & s_q.prev;
endmodule : eropt_sync
`default_nettype wire

// ### hdl/eropt_apb_regs.sv
// eropt_apb_regs: APB register file with sticky status and interrupt.
// Assumes an APB master; no wait states, data registered in setup.
`timescale 1ns/1ns
`default_nettype none
module eropt_apb_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eropt_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block side
    input wire logic [7:0] set_ev,
    input wire logic [31:0] state_in,
    output logic [31:0] ctrl,
    output logic [31:0] sa,
    output logic [7:0] stat,
    output logic irq
);
    import eropt_pkg::*;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] sa;
        logic [7:0] mask;
        logic [7:0] stat;
        logic [31:0] rdata;
        logic rdy;
        logic err;
        logic irq;
    } eropt_apb_s;
    eropt_apb_s s_q;
    eropt_apb_s s_d;
    logic [7:0] clr;

    always_comb
    begin
        s_d = s_q;
        clr = 8'h00;
        s_d.rdy = psel & ~penable;
        if (psel & ~penable)
        begin
            s_d.err = 1'b0;
            case (paddr)
                REG_CTRL: s_d.rdata = s_q.ctrl;
                REG_SA: s_d.rdata = s_q.sa;
                REG_STAT: s_d.rdata = {24'h000000, s_q.stat};
                REG_MASK: s_d.rdata = {24'h000000, s_q.mask};
                REG_STATE: s_d.rdata = state_in;
                default:
                begin
                    s_d.rdata = 32'h00000000;
                    s_d.err = 1'b1;
                end
            endcase
        end
        if (psel & penable & s_q.rdy)
        begin
            if (pwrite & ~s_q.err)
            begin
                case (paddr)
                    REG_CTRL: s_d.ctrl = pwdata & CTRL_WMASK;
                    REG_SA: s_d.sa = pwdata & SA_WMASK;
                    REG_MASK: s_d.mask = pwdata[7:0];
                    default: ;
                endcase
            end
            // Only bits seen by the read are cleared
            if (~pwrite & (paddr == REG_STAT))
                clr = s_q.rdata[7:0];
        end
        // New events win over the read clear
        s_d.stat = (s_q.stat & ~clr) | set_ev;
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
            s_q.sa <= SA_RST;
            s_q.mask <= MASK_RST;
        end
        else
            s_q <= s_d;
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.rdy;
    assign pslverr = s_q.err;
    assign ctrl = s_q.ctrl;
    assign sa = s_q.sa;
    assign stat = s_q.stat;
    assign irq = s_q.irq;
endmodule : eropt_apb_regs
`default_nettype wire

// ### hdl/eropt_top.sv
// eropt_top: receive output port of a four-channel E1 framer.
// Assumes framer, elastic store and HDLC receiver on clk; their streams
// hold each bit until the next falling edge of the clock that times them.
`timescale 1ns/1ns
`default_nettype none
module eropt_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eropt_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Clock and frame pins
    input wire logic [eropt_pkg::NCH-1:0] recovered_rx_clock,
    input wire logic bp_clock,
    input wire logic mux_clock,
    input wire logic mux_frame_pulse_in,
    input wire logic mux_enable_n,
    // Line-timed streams
    input wire logic [eropt_pkg::NCH-1:0] line_pcm,
    input wire logic [eropt_pkg::NCH-1:0] line_pos,
    input wire logic [eropt_pkg::NCH-1:0] line_neg,
    input wire logic [eropt_pkg::NCH-1:0] line_fsync,
    input wire logic [eropt_pkg::NCH-1:0] line_nfas,
    // Backplane-timed streams
    input wire logic [eropt_pkg::NCH-1:0] es_pcm,
    input wire logic [eropt_pkg::NCH-1:0] es_fsync,
    input wire logic [eropt_pkg::NCH-1:0][3:0] sig_abcd,
    // HDLC receiver events
    input wire logic [eropt_pkg::NCH-1:0] hdlc_event,
    input wire logic [eropt_pkg::NCH-1:0] hdlc_last_read,
    input wire logic [eropt_pkg::NCH-1:0] hdlc_overrun,
    // Data-link pins
    output logic [eropt_pkg::NCH-1:0] dlink_serial_out,
    output logic [eropt_pkg::NCH-1:0] dlink_clock_out,
    // Backplane pins
    output logic [eropt_pkg::NCH-1:0] bp_rx_pcm,
    output logic [eropt_pkg::NCH-1:0] bp_rx_signaling,
    output logic [eropt_pkg::NCH-1:0] bp_rx_pos_rail,
    output logic [eropt_pkg::NCH-1:0] bp_rx_neg_rail,
    output logic mux_rx_data
);
    import eropt_pkg::*;

    // =========================================================
    // State
    typedef struct packed {
        logic [NCH-1:0] pcm;
        logic [NCH-1:0] sig;
        logic [NCH-1:0] pos;
        logic [NCH-1:0] neg;
        logic [NCH-1:0] dl_dat;
        logic [NCH-1:0] dl_clk;
        logic [NCH-1:0] pin_sig;
        logic [NCH-1:0] pin_clk;
        logic [NCH-1:0][2:0] scnt;
        logic [NCH-1:0][7:0] lcnt;
        logic [2:0] slot;
        logic fp_seen;
        logic mux_dat;
    } eropt_top_s;
    eropt_top_s s_q;
    eropt_top_s s_d;

    logic [SYNC_W-1:0] pin_lvl;
    logic [SYNC_W-1:0] pin_rise;
    logic [SYNC_W-1:0] pin_fall;
    logic [NCH-1:0] rx_rise;
    logic [NCH-1:0] rx_fall;
    logic bp_fall;
    logic mux_rise;
    logic mux_fall;
    logic [31:0] ctrl;
    logic [31:0] sa;
    logic [7:0] stat;
    logic [31:0] state_rd;
    logic [7:0] set_ev;
    logic [NCH-1:0] hdlc_en;
    logic [NCH-1:0] frac_en;
    logic [NCH-1:0] bypass;
    logic [NCH-1:0] ts16_sel;
    logic [NCH-1:0] raw;
    logic [NCH-1:0] lt;
    logic line_timed_out_sel;
    logic dual_rail;
    logic [7:0] nl;
    logic [2:0] ns;
    logic [2:0] nslot;
    logic [4:0] saf;
    logic sel;
    logic adv;
    logic fs;
    logic dat;

    // =========================================================
    // Synchronisers and registers
    eropt_sync #(.W(SYNC_W)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din({mux_enable_n, mux_frame_pulse_in, mux_clock, bp_clock, recovered_rx_clock}),
        .lvl(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign rx_rise = pin_rise[NCH-1:0];
    assign rx_fall = pin_fall[NCH-1:0];
    assign bp_fall = pin_fall[SY_BP];
    assign mux_rise = pin_rise[SY_MCLK];
    assign mux_fall = pin_fall[SY_MCLK];

    assign hdlc_en = ctrl[CTRL_HDLC_EN +: NCH];
    assign frac_en = ctrl[CTRL_FRAC_EN +: NCH];
    assign bypass = ctrl[CTRL_BYPASS +: NCH];
    assign ts16_sel = ctrl[CTRL_TS16 +: NCH];
    assign line_timed_out_sel = ctrl[CTRL_LINE_TIMED];
    assign dual_rail = ctrl[CTRL_DUAL];
    assign raw = ~hdlc_en | frac_en;
    assign lt = bypass | {NCH{line_timed_out_sel}};
    // R5 receiver status events
    // R6 message end events
    assign set_ev = {(hdlc_last_read | hdlc_overrun) & hdlc_en, hdlc_event & hdlc_en};
    assign state_rd = {23'h000000, s_q.slot, pin_lvl[SY_MUX_ENABLE_N], raw, dual_rail};

    eropt_apb_regs u_regs (
        .clk(clk),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .set_ev(set_ev),
        .state_in(state_rd),
        .ctrl(ctrl),
        .sa(sa),
        .stat(stat),
        .irq(irq)
    );

    // =========================================================
    // Per-channel output logic
    always_comb
    begin
        s_d = s_q;
        nl = 8'h00;
        ns = 3'h0;
        nslot = 3'h0;
        saf = 5'h00;
        sel = 1'b0;
        adv = 1'b0;
        fs = 1'b0;
        dat = 1'b0;
        for (int ch = 0; ch < NCH; ch++)
        begin
            // Line-timed bit position, 256 bits a frame
            nl = line_fsync[ch] ? 8'h00 : s_q.lcnt[ch] + 8'h01;
            saf = sa[ch * SA_STRIDE +: 5];
            // R2 link bit select
            if (ts16_sel[ch])
                sel = (nl[7:3] == TS_DLINK);
            else
                sel = line_nfas[ch] & (nl[7:3] == 5'h00) & (nl[2:0] >= SA_FIRST_BIT)
                    & saf[nl[2:0] - SA_FIRST_BIT];
            if (rx_fall[ch])
            begin
                s_d.lcnt[ch] = nl;
                // R3 data with clock fall
                if (sel)
                begin
                    s_d.dl_dat[ch] = line_pcm[ch];
                    s_d.dl_clk[ch] = 1'b0;
                end
                // R10 positive rail NRZ
                // R11 recovered clock fall
                s_d.pos[ch] = dual_rail & line_pos[ch];
                // R17 negative rail NRZ
                s_d.neg[ch] = dual_rail & line_neg[ch];
            end
            // R4 rising sample edge
            if (rx_rise[ch])
                s_d.dl_clk[ch] = 1'b1;
            // R8 backplane timing
            // R9 line timing
            adv = lt[ch] ? rx_fall[ch] : bp_fall;
            fs = lt[ch] ? line_fsync[ch] : es_fsync[ch];
            dat = lt[ch] ? line_pcm[ch] : es_pcm[ch];
            if (adv)
            begin
                ns = fs ? 3'h0 : s_q.scnt[ch] + 3'h1;
                s_d.scnt[ch] = ns;
                // R7 stored extracted stream
                s_d.pcm[ch] = ~dual_rail & dat;
                // R16 bits five to eight
                s_d.sig[ch] = ~dual_rail & ns[2] & sig_abcd[ch][~ns[1:0]];
            end
            // R1 pin sharing
            s_d.pin_sig[ch] = raw[ch] ? s_d.dl_dat[ch] : stat[STAT_IRQ + ch];
            s_d.pin_clk[ch] = raw[ch] ? s_d.dl_clk[ch] : stat[STAT_EOM + ch];
        end
        // R13 frame pulse capture
        if (mux_rise & pin_lvl[SY_MFP])
            s_d.fp_seen = 1'b1;
        // R14 falling edge update
        if (mux_fall)
        begin
            // R18 ascending channel order
            nslot = s_q.fp_seen ? 3'h0 : s_q.slot + 3'h1;
            s_d.slot = nslot;
            s_d.fp_seen = 1'b0;
            // R12 interleave when enabled
            // R15 idle when disabled
            if (pin_lvl[SY_MUX_ENABLE_N])
                s_d.mux_dat = 1'b0;
            else
                s_d.mux_dat = nslot[0] ? s_q.sig[nslot[2:1]] : s_q.pcm[nslot[2:1]];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.dl_clk <= DLCLK_RST;
            s_q.pin_clk <= DLCLK_RST;
        end
        else
            s_q <= s_d;
    end

    assign dlink_serial_out = s_q.pin_sig;
    assign dlink_clock_out = s_q.pin_clk;
    assign bp_rx_pcm = s_q.pcm;
    assign bp_rx_signaling = s_q.sig;
    assign bp_rx_pos_rail = s_q.pos;
    assign bp_rx_neg_rail = s_q.neg;
    assign mux_rx_data = s_q.mux_dat;

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_fp_taken;
        mux_rise && pin_lvl[SY_MFP];
    endsequence
    sequence s_first_slot;
        $fell(s_q.fp_seen) && (s_q.slot == 3'h0);
    endsequence
    sequence s_hdlc_event;
        hdlc_event[0] && hdlc_en[0] && !frac_en[0] ##1 hdlc_en[0] && !frac_en[0];
    endsequence
    sequence s_msg_end;
        (hdlc_last_read[0] || hdlc_overrun[0]) && hdlc_en[0] && !frac_en[0] ##1 hdlc_en[0] && !frac_en[0];
    endsequence

    a_dlink_data_edge: assert property (($changed(dlink_serial_out[0]) && $past(raw[0]) && $past(raw[0], 2))
        |-> $fell(dlink_clock_out[0])) else $error("data-link data moved off clock fall"); // R3
    a_hdlc_irq_pin: assert property (s_hdlc_event |=> dlink_serial_out[0])
        else $error("receiver event not shown on interrupt pin"); // R5
    a_hdlc_msg_end: assert property (s_msg_end |=> dlink_clock_out[0])
        else $error("message end not shown on pin"); // R6
    a_pcm_bp_timing: assert property (($changed(bp_rx_pcm[0]) && $past(!lt[0])) |-> $past(bp_fall))
        else $error("pcm moved off backplane clock fall"); // R8
    a_pcm_line_timing: assert property (($changed(bp_rx_pcm[0]) && $past(lt[0])) |-> $past(rx_fall[0]))
        else $error("pcm moved off recovered clock fall"); // R9
    a_pos_rail_edge: assert property ($changed(bp_rx_pos_rail[0]) |-> $past(rx_fall[0]))
        else $error("positive rail moved off recovered clock fall"); // R11
    a_neg_rail_edge: assert property ($changed(bp_rx_neg_rail[0]) |-> $past(rx_fall[0]))
        else $error("negative rail moved off recovered clock fall"); // R17
    a_sig_bit_pos: assert property (bp_rx_signaling[0] |-> s_q.scnt[0][2])
        else $error("signaling outside bits five to eight"); // R16
    a_mux_data_edge: assert property ($changed(mux_rx_data) |-> $past(mux_fall))
        else $error("multiplexed data moved off clock fall"); // R14
    a_mux_frame_align: assert property (s_fp_taken |=> s_q.fp_seen ##[1:12] s_first_slot)
        else $error("channel one not first after frame pulse"); // R18
    a_mux_idle_off: assert property ($past(pin_lvl[SY_MUX_ENABLE_N]) && $past(mux_fall) |-> !mux_rx_data)
        else $error("multiplexed output active while disabled"); // R15
endmodule : eropt_top
`default_nettype wire

// ### sim/eropt_far_end.sv
// eropt_far_end: backplane logic and data-link controller facing the port.
// Assumes the bench reads the captured words between frames.
`timescale 1ns/1ns
`default_nettype none
module eropt_far_end
(
    // Multiplex side
    output var logic mux_clock,
    output var logic mux_frame_pulse_in,
    input wire logic mux_rx_data,
    output var logic [7:0] mux_word,
    // Data-link side of one channel
    input wire logic dl_clk,
    input wire logic dl_data,
    output var logic [7:0] dl_word,
    output var logic [7:0] dl_cnt
);
    logic [7:0] mux_sh = 8'h00;
    logic [2:0] slot = 3'h0;
    initial dl_cnt = 8'h00;
    // ==========
    // Multiplex clock, eight slots a frame
    initial
    begin
        mux_clock = 1'b0;
        #7;
        forever #50 mux_clock = ~mux_clock;
    end
    always @(negedge mux_clock)
        mux_frame_pulse_in <= (slot == 3'h7);
    // Slot 0 sits in the MSB of the word
    always @(posedge mux_clock)
    begin
        mux_sh <= {mux_sh[6:0], mux_rx_data};
        slot <= slot + 3'h1;
        if (slot == 3'h7)
            mux_word <= {mux_sh[6:0], mux_rx_data};
    end
    always @(posedge dl_clk)
    begin
        dl_word <= {dl_word[6:0], dl_data};
        dl_cnt <= dl_cnt + 8'h01;
    end
endmodule : eropt_far_end
`default_nettype wire

// ### sim/test_eropt_top.sv
// test_eropt_top: self-checking bench of the E1 receive output port.
// Assumes eropt_pkg and the far-end model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_eropt_top;
    import eropt_pkg::*;
    localparam logic [7:0] DLB = 8'hC5;
    logic clk, rclk, bp_clock, mux_clock, mux_frame_pulse_in, mux_rx_data, pready, pslverr, irq, rerr;
    logic arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mux_enable_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, st;
    logic [3:0] line_pcm = 4'h0, line_pos = 4'h0, line_neg = 4'h0, line_fsync = 4'h0, es_pcm = 4'h0;
    logic [3:0] hdlc_event = 4'h0, hdlc_last_read = 4'h0, hdlc_overrun = 4'h0;
    logic [3:0] dlink_serial_out, dlink_clock_out, bp_rx_pcm, bp_rx_signaling, bp_rx_pos_rail, bp_rx_neg_rail;
    logic [3:0] ar = 4'hF, ab = 4'hF, am = 4'hF, pv_pcm, pv_pos, pv_neg;
    logic rp = 1'b0, bpp = 1'b0, mp = 1'b0, pv_mux, pv_dl, hold = 1'b0, mon_en = 1'b0, lt = 1'b0, raw = 1'b1;
    logic so = 1'b0;
    logic [15:0] sga = 16'h0000;
    logic [7:0] bi = 8'h00, mux_word, dl_word, dl_cnt, c0;
    logic [7:0] ra [3] = '{REG_CTRL, REG_SA, REG_MASK};
    logic [31:0] rr [3] = '{CTRL_RST, SA_RST, {24'h0, MASK_RST}};
    logic [31:0] rw [3] = '{CTRL_WMASK, SA_WMASK, 32'h000000FF};
    int error_cnt = 0, n_checks = 0;
    eropt_top u_eropt_top (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .recovered_rx_clock({4{rclk}}), .bp_clock, .mux_clock, .mux_frame_pulse_in,
        .mux_enable_n, .line_pcm, .line_pos, .line_neg, .line_fsync, .line_nfas(4'hF), .es_pcm,
        .es_fsync(4'h0), .sig_abcd(sga), .hdlc_event, .hdlc_last_read, .hdlc_overrun, .dlink_serial_out,
        .dlink_clock_out, .bp_rx_pcm, .bp_rx_signaling, .bp_rx_pos_rail, .bp_rx_neg_rail, .mux_rx_data);
    eropt_far_end u_eropt_far_end (.mux_clock, .mux_frame_pulse_in, .mux_rx_data, .mux_word,
        .dl_clk(dlink_clock_out[0]), .dl_data(dlink_serial_out[0]), .dl_word, .dl_cnt);
    // ==========
    // Clocks; edges never meet a clk rise
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        rclk = 1'b0;
        #1;
        forever
        begin
            #62 rclk = ~rclk;
            #63 rclk = ~rclk;
        end
    end
    initial
    begin
        bp_clock = 1'b0;
        #2;
        forever #75 bp_clock = ~bp_clock;
    end
    // ==========
    // Helpers
    function automatic logic [3:0] age(input logic p, input logic n, input logic [3:0] c);
        return (p & ~n) ? 4'h0 : ((c == 4'hF) ? c : c + 4'h1);
    endfunction : age
    // Timeslot 16 carries DLB, other bits toggle
    function automatic logic lbit(input logic [7:0] b);
        return (b[7:3] == 5'h10) ? DLB[3'h7 - b[2:0]] : b[0];
    endfunction : lbit
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic timeout_stop;
        error_cnt++;
        report_and_stop();
    endtask : timeout_stop
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            timeout_stop();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_bit(input logic [7:0] v);
        int n;
        n = 0;
        while (bi !== v && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000)
            timeout_stop();
    endtask : wait_bit
    task automatic setmode(input logic [31:0] c, input int n);
        mon_en <= 1'b0;
        apb(1'b1, REG_CTRL, c);
        lt <= (c[11:8] != 4'h0) || c[CTRL_LINE_TIMED];
        raw <= (c[3:0] == 4'h0);
        repeat (30) @(posedge clk);
        mon_en <= 1'b1;
        repeat (n) @(posedge clk);
    endtask : setmode
    task automatic pulse(input logic [3:0] ev, input logic [3:0] lr, input logic [3:0] ov);
        hdlc_event <= ev;
        hdlc_last_read <= lr;
        hdlc_overrun <= ov;
        @(posedge clk);
        hdlc_event <= 4'h0;
        hdlc_last_read <= 4'h0;
        hdlc_overrun <= 4'h0;
        repeat (4) @(posedge clk);
    endtask : pulse
    // ==========
    // Stream stimulus and edge-timing monitor
    always @(posedge clk)
    begin
        rp <= rclk;
        bpp <= bp_clock;
        mp <= mux_clock;
        ar <= age(rp, rclk, ar);
        ab <= age(bpp, bp_clock, ab);
        am <= age(mp, mux_clock, am);
        {pv_pcm, pv_pos, pv_neg, pv_mux, pv_dl} <= {bp_rx_pcm, bp_rx_pos_rail, bp_rx_neg_rail, mux_rx_data,
            dlink_serial_out[0]};
        if (rp & ~rclk)
        begin
            bi <= bi + 8'h01;
            line_fsync <= {4{bi == 8'hFF}};
            line_pcm <= hold ? 4'h9 : {4{lbit(bi + 8'h01)}};
            line_pos <= hold ? 4'h5 : {4{bi[0]}};
            line_neg <= hold ? 4'hA : {4{bi[1]}};
        end
        if (bpp & ~bp_clock)
            es_pcm <= hold ? 4'h3 : ~es_pcm;
        if (mon_en && bp_rx_pcm !== pv_pcm)
            chk("pcm_edge", 32'h1, 32'((lt ? ar : ab) inside {[4'h2:4'h5]}));
        if (mon_en && {bp_rx_pos_rail, bp_rx_neg_rail} !== {pv_pos, pv_neg})
            chk("rail_edge", 32'h1, 32'(ar inside {[4'h2:4'h5]}));
        if (mon_en && mux_rx_data !== pv_mux)
            chk("mux_edge", 32'h1, 32'(am inside {[4'h2:4'h5]}));
        if (mon_en && raw && dlink_serial_out[0] !== pv_dl)
            chk("dl_edge", 32'h0, {31'h0, dlink_clock_out[0]});
        if (so && rp & ~rclk)
            chk("sig_pos", {31'h0, bi[2:0] == 3'h4}, {31'h0, bp_rx_signaling[0]});
    end
    // ==========
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        chk("rst_pins", 32'h0000F000, {14'h0, irq, mux_rx_data, dlink_clock_out, dlink_serial_out, bp_rx_pcm,
            bp_rx_pos_rail});
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            chk("reg_reset", rr[i], rdat);
            apb(1'b1, ra[i], 32'hFFFFFFFF);
            apb(1'b0, ra[i], 32'h0);
            chk("reg_write", rw[i], rdat);
        end
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        chk("unmapped_wr_err", 32'h1, {31'h0, rerr});
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_rd", 32'h1, {rdat[30:0], rerr});
        apb(1'b1, REG_MASK, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0000000F);
        apb(1'b0, REG_STATE, 32'h0);
        st = rdat;
        chk("state_raw", 32'h0, rdat & 32'h1E);
        apb(1'b1, REG_STATE, 32'hFFFFFFFF);
        chk("state_wr_err", 32'h0, {31'h0, rerr});
        apb(1'b0, REG_STATE, 32'h0);
        chk("state_ro", st & 32'h3F, rdat & 32'h3F);
        pulse(4'h3, 4'h0, 4'h0);
        chk("irq_pin", 32'h3, {28'h0, dlink_serial_out});
        chk("irq_masked", 32'h0, {31'h0, irq});
        pulse(4'h0, 4'h8, 4'h5);
        chk("eom_pin", 32'hD, {28'h0, dlink_clock_out});
        apb(1'b1, REG_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq_set", 32'h1, {31'h0, irq});
        apb(1'b0, REG_STAT, 32'h0);
        chk("stat", 32'hD3, rdat);
        repeat (2) @(posedge clk);
        chk("cleared", 32'h0, {23'h0, irq, dlink_clock_out, dlink_serial_out});
        apb(1'b1, REG_CTRL, 32'h000000FF);
        apb(1'b0, REG_STATE, 32'h0);
        chk("state_frac", 32'h1E, rdat & 32'h1E);
        setmode(32'h0000FF00, 0);
        wait_bit(8'd200);
        c0 = dl_cnt;
        wait_bit(8'd100);
        wait_bit(8'd200);
        chk("dl_clocks", 32'h8, {24'h0, dl_cnt - c0});
        chk("dl_byte", {24'h0, DLB}, {24'h0, dl_word});
        setmode(32'h00010000, 300);
        setmode(32'h0000F000, 300);
        setmode(32'h00020000, 300);
        hold <= 1'b1;
        setmode(32'h0, 300);
        chk("pcm_es", 32'h3, {28'h0, bp_rx_pcm});
        chk("mux_word", 32'hA0, {24'h0, mux_word});
        mux_enable_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk("mux_off", 32'h3, {27'h0, mux_rx_data, bp_rx_pcm});
        sga <= 16'h8888;
        setmode(32'h00000F00, 0);
        wait_bit(8'hC8);
        c0 = dl_cnt;
        wait_bit(8'h64);
        so <= 1'b1;
        wait_bit(8'hC8);
        so <= 1'b0;
        chk("dl_sa", 32'h5, {24'h0, dl_cnt - c0});
        chk("pcm_bypass", 32'h9, {28'h0, bp_rx_pcm});
        setmode(32'h00020000, 100);
        chk("dual_rail", 32'h5A0, {20'h0, bp_rx_pos_rail, bp_rx_neg_rail, bp_rx_pcm});
        report_and_stop();
    end
endmodule : test_eropt_top
`default_nettype wire
